// >>> hdl/eept_pkg.sv
// Constants shared by the event edge path trigger block
package eept_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_EVT = 4;
  localparam int SEL_W = 4;
  localparam int MAP_W = 16;
  localparam int PATH_W = 7;
  localparam int ADR_W = 16;
  localparam int IDX_W = 14;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] RISE_MAP_IDX = 14'h05c4;
  localparam logic [IDX_W-1:0] FALL_MAP_IDX = 14'h05c6;
  localparam logic [IDX_W-1:0] CTRL_IDX = 14'h05c8;
  localparam logic [IDX_W-1:0] STAT_IDX = 14'h05ca;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam logic [MAP_W-1:0] MAP_RESET = 16'h0000;
  localparam logic MODE_RESET = 1'b0;
  localparam int CTRL_MODE_BIT = 0;
  localparam int STAT_PATH_LSB = 0;
  localparam int STAT_PEND_LSB = 8;
  localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;
  localparam logic [SEL_W-1:0] SEL_MAX = 4'hd;
  localparam logic [PATH_W-1:0] PATH_BASE = 7'h32;
  localparam logic [PATH_W-1:0] FIRST_EVENT_PATH = 7'h33;
  localparam logic [PATH_W-1:0] LAST_EVENT_PATH = 7'h3f;

endpackage : eept_pkg

// >>> hdl/eept_evt_if.sv
// Synchronised event levels and edge pulses between the two modules
`timescale 1ns/1ps
`default_nettype none
interface eept_evt_if #(parameter int N = 4);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : eept_evt_if
`default_nettype wire

// >>> hdl/eept_edge_sync.sv
// Two-stage synchroniser and edge detector for the event inputs
`timescale 1ns/1ps
`default_nettype none
module eept_edge_sync #(
  parameter int N = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [N-1:0] event_i,
  eept_evt_if.src evt
);
  import eept_pkg::*;

  logic [N-1:0] meta;
  logic [N-1:0] sync;
  logic [N-1:0] held;

  // ----------------------------------------------------------------
  // Synchroniser chain and previous level
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      sync <= '0;
      held <= '0;
    end else if (ce_i) begin
      meta <= event_i;
      sync <= meta;
      held <= sync;
    end
  end

  // Edge pulses last one enabled cycle each
  assign evt.level = held;
  assign evt.rise = sync & ~held;
  assign evt.fall = ~sync & held;

endmodule : eept_edge_sync
`default_nettype wire

// >>> hdl/eept_trigger.sv
// Event edge to positioning path launcher with Wishbone registers
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module eept_trigger (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [eept_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [eept_pkg::NUM_EVT-1:0] event_i,
  output logic launch_valid_o,
  output logic [eept_pkg::PATH_W-1:0] launch_path_o,
  output logic path_register_mode_o
);
  import eept_pkg::*;

  localparam int NP = 2 * NUM_EVT;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  eept_evt_if #(.N(NUM_EVT)) evt ();

  // Synchronised edges for all event inputs
  eept_edge_sync #(.N(NUM_EVT)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .event_i(event_i),
    .evt(evt)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [MAP_W-1:0] rise_trigger_map;
  logic [MAP_W-1:0] fall_trigger_map;
  logic path_register_mode;
  logic [PATH_W-1:0] last_path;
  logic [NP-1:0] pend;
  logic [SEL_W-1:0] pend_sel [NP];

  // Nibble-wise write; out-of-range nibbles keep their old value
  function automatic logic [MAP_W-1:0] map_write(
    input logic [MAP_W-1:0] old,
    input logic [MAP_W-1:0] wdat,
    input logic [1:0] lanes
  );
    logic [MAP_W-1:0] res;
    res = old;
    for (int i = 0; i < NUM_EVT; i++) begin
      if (lanes[i/2] && (wdat[SEL_W*i +: SEL_W] <= SEL_MAX)) begin
        res[SEL_W*i +: SEL_W] = wdat[SEL_W*i +: SEL_W];
      end
    end
    return res;
  endfunction : map_write

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [IDX_W-1:0] adr_idx = wb_adr_i[ADR_W-1:2];
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & ce_i;
  wire hit_rise = (adr_idx == RISE_MAP_IDX);
  wire hit_fall = (adr_idx == FALL_MAP_IDX);
  wire hit_ctrl = (adr_idx == CTRL_IDX);
  wire hit_stat = (adr_idx == STAT_IDX);
  wire [31:0] stat_word = {16'h0000, pend, 1'b0, last_path};
  logic [31:0] rd_word;

  // Read multiplexer, unmapped reads return zero
  always_comb begin
    if (hit_rise) begin
      rd_word = {16'h0000, rise_trigger_map};
    end else if (hit_fall) begin
      rd_word = {16'h0000, fall_trigger_map};
    end else if (hit_ctrl) begin
      rd_word = {31'h00000000, path_register_mode};
    end else if (hit_stat) begin
      rd_word = stat_word;
    end else begin
      rd_word = 32'h00000000;
    end
  end

  // Bus answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_word : 32'h00000000;
    end
  end

  // Trigger maps and mode control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rise_trigger_map <= MAP_RESET;
      fall_trigger_map <= MAP_RESET;
      path_register_mode <= MODE_RESET;
    end else if (bus_wr) begin
      if (hit_rise) begin
        rise_trigger_map <= map_write(rise_trigger_map, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (hit_fall) begin
        fall_trigger_map <= map_write(fall_trigger_map, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (hit_ctrl && wb_sel_i[0]) begin
        path_register_mode <= wb_dat_i[CTRL_MODE_BIT];
      end
    end
  end

  assign path_register_mode_o = path_register_mode;

  // ----------------------------------------------------------------
  // Launch requests
  // ----------------------------------------------------------------
  // Entry 2i is rising of input i, entry 2i+1 its falling edge
  logic [NP-1:0] pend_set;
  logic [SEL_W-1:0] edge_sel [NP];
  logic [NP-1:0] serve_oh;
  logic [SEL_W-1:0] serve_sel;
  logic [NP-1:0] next_pend;

  // Selector chosen for every possible edge
  always_comb begin
    for (int i = 0; i < NUM_EVT; i++) begin
      edge_sel[2*i] = rise_trigger_map[SEL_W*i +: SEL_W];
      edge_sel[2*i+1] = fall_trigger_map[SEL_W*i +: SEL_W];
      pend_set[2*i] = path_register_mode & evt.rise[i] & (edge_sel[2*i] != SEL_NONE);
      pend_set[2*i+1] = path_register_mode & evt.fall[i] & (edge_sel[2*i+1] != SEL_NONE);
    end
  end

  // Lowest pending entry is served first
  assign serve_oh = pend & (~pend + {{(NP-1){1'b0}}, 1'b1});

  // Selector of the served entry
  always_comb begin
    serve_sel = SEL_NONE;
    for (int k = 0; k < NP; k++) begin
      if (serve_oh[k]) begin
        serve_sel = pend_sel[k];
      end
    end
  end

  // New edges win over the serving clear; leaving the mode drops all
  assign next_pend = path_register_mode ? ((pend & ~serve_oh) | pend_set) : '0;

  // Pending edges and their captured selectors
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend <= '0;
      for (int k = 0; k < NP; k++) begin
        pend_sel[k] <= SEL_NONE;
      end
    end else if (ce_i) begin
      pend <= next_pend;
      for (int k = 0; k < NP; k++) begin
        if (pend_set[k]) begin
          pend_sel[k] <= edge_sel[k];
        end
      end
    end
  end

  // One-cycle launch pulse with path number
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      launch_valid_o <= 1'b0;
      launch_path_o <= '0;
      last_path <= '0;
    end else if (ce_i) begin
      launch_valid_o <= path_register_mode & (|serve_oh);
      if (path_register_mode && (|serve_oh)) begin
        launch_path_o <= PATH_BASE + {3'b000, serve_sel};
        last_path <= PATH_BASE + {3'b000, serve_sel};
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_map_reset;
    @(posedge clk_i) $past(rst_i) && !rst_i |-> (rise_trigger_map == MAP_RESET)
      && (fall_trigger_map == MAP_RESET);
  endproperty
  a_map_reset: assert property (p_map_reset) else $error("maps not zero after reset");

  property p_rise_range;
    @(posedge clk_i) disable iff (rst_i)
      (rise_trigger_map[3:0] <= SEL_MAX) && (rise_trigger_map[7:4] <= SEL_MAX)
      && (rise_trigger_map[11:8] <= SEL_MAX) && (rise_trigger_map[15:12] <= SEL_MAX);
  endproperty
  a_rise_range: assert property (p_rise_range) else $error("rise selector above D");

  property p_fall_range;
    @(posedge clk_i) disable iff (rst_i)
      bus_wr && hit_fall && (wb_sel_i[1:0] == 2'b11) && (wb_dat_i[15:0] == 16'hdddd)
      |=> fall_trigger_map == 16'hdddd;
  endproperty
  a_fall_range: assert property (p_fall_range) else $error("fall map write lost");

  property p_rise_zero;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && evt.rise[0] && (rise_trigger_map[3:0] == SEL_NONE) && !pend[0] |=> !pend[0];
  endproperty
  a_rise_zero: assert property (p_rise_zero) else $error("zero selector queued launch");

  property p_fall_zero;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && evt.fall[0] && (fall_trigger_map[3:0] == SEL_NONE) && !pend[1] |=> !pend[1];
  endproperty
  a_fall_zero: assert property (p_fall_zero) else $error("zero selector queued launch");

  property p_rise_one;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && path_register_mode && pend[0]
      |=> launch_valid_o && (launch_path_o == PATH_BASE + {3'b000, $past(pend_sel[0])});
  endproperty
  a_rise_one: assert property (p_rise_one) else $error("input one rise path wrong");

  property p_rise_two;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && path_register_mode && evt.rise[1] && (rise_trigger_map[7:4] != SEL_NONE)
      |=> pend[2] && (pend_sel[2] == $past(rise_trigger_map[7:4]));
  endproperty
  a_rise_two: assert property (p_rise_two) else $error("input two rise not queued");

  property p_fall_one;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && path_register_mode && evt.fall[0] && (fall_trigger_map[3:0] != SEL_NONE)
      ##1 ce_i && path_register_mode && (pend[0] == 1'b0)
      |=> launch_valid_o && (launch_path_o == PATH_BASE + {3'b000, $past(pend_sel[1])});
  endproperty
  a_fall_one: assert property (p_fall_one) else $error("input one fall path wrong");

  property p_fall_four;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && path_register_mode && evt.fall[3] && (fall_trigger_map[15:12] != SEL_NONE)
      |=> pend[7];
  endproperty
  a_fall_four: assert property (p_fall_four) else $error("input four fall not queued");

  property p_mode_gate;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && !path_register_mode |=> !launch_valid_o && (pend == '0);
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("launch outside path mode");

  property p_launch_range;
    @(posedge clk_i) disable iff (rst_i)
      launch_valid_o |-> (launch_path_o >= FIRST_EVENT_PATH)
      && (launch_path_o <= LAST_EVENT_PATH) && $past(|pend);
  endproperty
  a_launch_range: assert property (p_launch_range) else $error("launch path out of range");

  property p_edge_high;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && (evt.rise != '0)
      |=> (evt.level & $past(evt.rise)) == $past(evt.rise);
  endproperty
  a_edge_high: assert property (p_edge_high) else $error("rising edge not registered");

  property p_edge_low;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && (evt.fall != '0)
      |=> (evt.level & $past(evt.fall)) == '0;
  endproperty
  a_edge_low: assert property (p_edge_low) else $error("falling edge not registered");

  property p_edge_once;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && ((evt.rise | evt.fall) != '0)
      |=> ((evt.rise & $past(evt.rise)) == '0) && ((evt.fall & $past(evt.fall)) == '0);
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge pulse repeated");

  property p_rise_three;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && path_register_mode && evt.rise[2] && (rise_trigger_map[11:8] != SEL_NONE)
      |=> pend[4] && (pend_sel[4] == $past(rise_trigger_map[11:8]));
  endproperty
  a_rise_three: assert property (p_rise_three) else $error("input three rise not queued");

  property p_rise_four;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && path_register_mode && evt.rise[3] && (rise_trigger_map[15:12] != SEL_NONE)
      |=> pend[6] && (pend_sel[6] == $past(rise_trigger_map[15:12]));
  endproperty
  a_rise_four: assert property (p_rise_four) else $error("input four rise not queued");

  property p_fall_two;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && path_register_mode && evt.fall[1] && (fall_trigger_map[7:4] != SEL_NONE)
      |=> pend[3] && (pend_sel[3] == $past(fall_trigger_map[7:4]));
  endproperty
  a_fall_two: assert property (p_fall_two) else $error("input two fall not queued");

  property p_fall_three;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && path_register_mode && evt.fall[2] && (fall_trigger_map[11:8] != SEL_NONE)
      |=> pend[5] && (pend_sel[5] == $past(fall_trigger_map[11:8]));
  endproperty
  a_fall_three: assert property (p_fall_three) else $error("input three fall not queued");

  property p_rise_hold;
    @(posedge clk_i) disable iff (rst_i)
      bus_wr && hit_rise && wb_sel_i[0] && (wb_dat_i[7:4] > SEL_MAX)
      |=> rise_trigger_map[7:4] == $past(rise_trigger_map[7:4]);
  endproperty
  a_rise_hold: assert property (p_rise_hold) else $error("illegal rise selector stored");

  property p_fall_hold;
    @(posedge clk_i) disable iff (rst_i)
      bus_wr && hit_fall && wb_sel_i[0] && (wb_dat_i[7:4] > SEL_MAX)
      |=> fall_trigger_map[7:4] == $past(fall_trigger_map[7:4]);
  endproperty
  a_fall_hold: assert property (p_fall_hold) else $error("illegal fall selector stored");

  property p_mode_reset;
    @(posedge clk_i) $past(rst_i) && !rst_i |-> !path_register_mode && !launch_valid_o;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("path mode set after reset");

endmodule : eept_trigger
`default_nettype wire

// >>> testbench/eept_event_src.sv
// Model of the machine signals feeding the event inputs
`timescale 1ns/1ps
`default_nettype none
module eept_event_src (
  input wire logic clk_i,
  input wire logic [3:0] level_i,
  output logic [3:0] event_o
);
  // Machine levels change just after a clock edge, idle inactive
  initial event_o = 4'h0;
  always @(posedge clk_i) begin
    event_o <= level_i;
  end
endmodule : eept_event_src
`default_nettype wire

// >>> testbench/event_edge_path_trigger_bench.sv
// Self-checking bench for the event edge path trigger
`timescale 1ns/1ps
`default_nettype none
module event_edge_path_trigger_bench;
  import eept_pkg::*;
  localparam logic [15:0] A_RISE = {RISE_MAP_IDX, 2'b00};
  localparam logic [15:0] A_FALL = {FALL_MAP_IDX, 2'b00};
  localparam logic [15:0] A_CTRL = {CTRL_IDX, 2'b00};
  localparam logic [15:0] A_STAT = {STAT_IDX, 2'b00};
  logic ce = 1'b1;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [15:0] wb_adr = 16'h0000;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [3:0] lvl_cmd = 4'h0;
  logic [3:0] evt;
  logic lv;
  logic [6:0] lpath;
  logic mode;
  logic [6:0] last_path = 7'h00;
  int launches = 0;
  int err_count = 0;
  int cmp_count = 0;

  // ---------------------------------------------------------------
  // Clock, design and partner
  // ---------------------------------------------------------------
  always #20 clk_i = ~clk_i;
  eept_event_src src (.clk_i(clk_i), .level_i(lvl_cmd), .event_o(evt));
  eept_trigger uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .event_i(evt), .launch_valid_o(lv),
    .launch_path_o(lpath), .path_register_mode_o(mode)
  );
  // Launch pulse monitor
  always @(posedge clk_i) begin
    if (lv === 1'b1) begin
      launches = launches + 1;
      last_path = lpath;
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check
  task results;
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
           output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdat;
    if (n >= 20) err_count++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : bus
  task wr(input logic [15:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, {16'h0000, d}, 4'hf, q);
  endtask : wr
  task rd(input string name, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    check(name, q, exp);
  endtask : rd
  task edge_case(input int i, input logic l, input int n, input logic [6:0] p);
    launches = 0;
    @(posedge clk_i);
    lvl_cmd[i] <= l;
    repeat (12) @(posedge clk_i);
    check("launch count", 32'(launches), 32'(n));
    if (n != 0) check("launch path", {25'h0, last_path}, {25'h0, p});
  endtask : edge_case

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset_values;
    rd("rise map", A_RISE, 32'h0);
    rd("fall map", A_FALL, 32'h0);
    rd("control", A_CTRL, 32'h0);
  endtask : t_reset_values
  task t_map_access;
    logic [31:0] q;
    wr(A_RISE, 16'h0033);
    wr(A_RISE, 16'h00e5);
    rd("rise map", A_RISE, 32'h0000_0035);
    bus(1'b1, A_RISE, 32'h0000_dddd, 4'h1, q);
    rd("rise map", A_RISE, 32'h0000_00dd);
    wr(A_FALL, 16'hdddd);
    wr(A_FALL, 16'hddfd);
    rd("fall map", A_FALL, 32'h0000_dddd);
    wr(16'h1730, 16'h1234);
    rd("unmapped", 16'h1730, 32'h0);
  endtask : t_map_access
  task t_mode_gate;
    wr(A_CTRL, 16'h0000);
    check("mode", {31'h0, mode}, 32'h0);
    edge_case(0, 1'b1, 0, 7'h00);
    edge_case(0, 1'b0, 0, 7'h00);
    wr(A_CTRL, 16'h0001);
    rd("control", A_CTRL, 32'h1);
    check("mode", {31'h0, mode}, 32'h1);
  endtask : t_mode_gate
  task t_sweep;
    for (int i = 0; i < 4; i++) begin
      for (int s = 0; s < 14; s++) begin
        wr(A_RISE, 16'(s) << (4 * i));
        wr(A_FALL, 16'(13 - s) << (4 * i));
        edge_case(i, 1'b1, s != 0, PATH_BASE + 7'(s));
        edge_case(i, 1'b0, s != 13, PATH_BASE + 7'(13 - s));
      end
    end
  endtask : t_sweep
  task t_freeze;
    launches = 0;
    @(posedge clk_i);
    ce <= 1'b0;
    lvl_cmd[3] <= 1'b1;
    repeat (12) @(posedge clk_i);
    check("frozen launches", 32'(launches), 32'h0);
    ce <= 1'b1;
    edge_case(3, 1'b1, 1, LAST_EVENT_PATH);
    edge_case(3, 1'b0, 0, 7'h00);
    rd("status", A_STAT, {25'h0, LAST_EVENT_PATH});
  endtask : t_freeze
  task t_reset_again;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    rd("status", A_STAT, 32'h0);
  endtask : t_reset_again

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_map_access();
    t_mode_gate();
    t_sweep();
    t_freeze();
    t_reset_again();
    results();
  end
  initial begin
    #400000;
    err_count++;
    results();
  end
endmodule : event_edge_path_trigger_bench
`default_nettype wire
